// ==== shared/alarm_cfg_pkg.sv ====
// package: constants and carrier types for alarm interrupt and strap logic
package alarm_cfg_pkg;

  // register offsets of the plain register port
  localparam logic [3:0] OFS_GLOBAL = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h1;
  localparam logic [3:0] OFS_MASK   = 4'h2;
  localparam logic [3:0] OFS_ALARM  = 4'h3;
  localparam logic [3:0] OFS_JITTER = 4'h4;

  // global register fields
  localparam int GLB_IRQ_EN_BIT    = 0;
  localparam int GLB_AUTO_ONES_BIT = 1;
  localparam logic [7:0] GLOBAL_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET   = 8'hFF;

  localparam int CHANNELS = 8;

  // reference clock figure and sampling rate
  localparam real REF_CLOCK_MHZ = 2.048;
  localparam real SYS_CLOCK_MHZ = 100.0;
  // longest number of system cycles between reference edges before it counts as stopped
  localparam int  REF_TIMEOUT_CYC = 2 * $rtoi(SYS_CLOCK_MHZ / REF_CLOCK_MHZ);

  // jitter attenuator strap codes
  localparam logic [1:0] JA_OFF     = 2'h0;
  localparam logic [1:0] JA_TX_10HZ = 2'h1;
  localparam logic [1:0] JA_RX_10HZ = 2'h2;
  localparam logic [1:0] JA_RX_1HZ5 = 2'h3;
  localparam logic [6:0] FIFO_DEPTH_32 = 7'h20;
  localparam logic [6:0] FIFO_DEPTH_64 = 7'h40;

  typedef enum logic [1:0] {JA_PATH_NONE, JA_PATH_TX, JA_PATH_RX} ja_path_e;

  typedef struct packed {
    ja_path_e   path;
    logic       narrowBand;
    logic [6:0] fifoDepth;
  } ja_cfg_s;

  // open-drain pin carrier
  typedef struct packed {
    logic out;
    logic oe;
  } od_pin_s;

endpackage

// ==== hw/sync_two_ff.sv ====
// module: two flip-flop synchroniser for levels entering the clock domain
`timescale 1ns/1ps
module sync_two_ff #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1_ff;

  always_ff @(posedge clk) begin
    if (reset) begin
      stage1_ff <= '0;
      syncOut   <= '0;
    end else begin
      stage1_ff <= asyncIn;
      syncOut   <= stage1_ff;
    end
  end
endmodule // sync_two_ff

// ==== hw/alarm_irq_strap.sv ====
// module: alarm interrupt, auto all-ones, jitter strap decode, clock pass-through
// What this block does
// RULE_01: in synchronous host bus mode, bus logic is clocked by the host bus clock; this block keeps its register port on clk and only raises busClockSel.
// RULE_02: hardware mode with strap set: send all ones while signal is lost.
// RULE_03: host mode: same all-ones behaviour, enabled by a global register bit.
// RULE_04: host mode: interrupt pin pulled low whenever any alarm status changes.
// RULE_05: reading the status register clears pending alarms and releases the pin.
// RULE_06: interrupts only raised while the global interrupt enable bit is high.
// RULE_07: interrupt pin is open drain: drives low or releases, never high.
// RULE_08: synthesized master clock is presented at the E1 rate on its output.
// RULE_09: outside source supplies 2.048 MHz reference, 50 ppm, 40-60 % duty.
// RULE_10: jitter straps: off, tx 10 Hz/32, rx 10 Hz/32, rx 1.5 Hz/64.
// RULE_11: mode select high means hardware mode, low means host mode.
//
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/1ps
module alarm_irq_strap #(
  parameter int CHANNELS = alarm_cfg_pkg::CHANNELS
) (
  input  wire logic                clk,
  input  wire logic                reset,
  input  wire logic                config_mode_select,
  input  wire logic                auto_all_ones_on_los,
  input  wire logic                jitter_path_select_lo,
  input  wire logic                jitter_path_select_hi,
  input  wire logic                e1_reference_clock_in,
  input  wire logic                hostBusClock,
  input  wire logic                syncBusMode,
  input  wire logic [CHANNELS-1:0] lossOfSignal,
  input  wire logic [CHANNELS-1:0] txPos,
  input  wire logic [CHANNELS-1:0] txNeg,
  input  wire logic [3:0]          regAddr,
  input  wire logic [7:0]          regWrData,
  input  wire logic                regWrite,
  input  wire logic                regRead,
  output logic      [7:0]          regRdData,
  output logic      [CHANNELS-1:0] line_tx_pos,
  output logic      [CHANNELS-1:0] line_tx_neg,
  output logic                     alarmIrqOut,
  output logic                     alarmIrqOe,
  output logic                     synth_master_clock_out,
  output logic                     refClockPresent,
  output alarm_cfg_pkg::ja_cfg_s   jitterCfg,
  output logic                     busClockSel
);

  if (CHANNELS < 1 || CHANNELS > 8) begin : g_bad_channels
    $error("CHANNELS must be 1 to 8");
  end

  // ***************************************
  // input synchronisers
  // ***************************************
  localparam int SW = CHANNELS + 6;
  logic [SW-1:0] rawIn;
  logic [SW-1:0] syncIn;
  assign rawIn = {lossOfSignal, config_mode_select, auto_all_ones_on_los,
                  jitter_path_select_hi, jitter_path_select_lo,
                  e1_reference_clock_in, syncBusMode};

  sync_two_ff #(.WIDTH(SW)) u_sync (
    .clk     (clk),
    .reset   (reset),
    .asyncIn (rawIn),
    .syncOut (syncIn)
  );

  logic [CHANNELS-1:0] losSync;
  logic                hwMode;
  logic                strapAllOnes;
  logic [1:0]          jaStrap;
  logic                refSync;
  logic                syncBusSync;
  logic                refRise;
  assign losSync      = syncIn[SW-1:6];
  assign hwMode       = syncIn[5]; // RULE_11
  assign strapAllOnes = syncIn[4];
  assign jaStrap      = syncIn[3:2];
  assign refSync      = syncIn[1];
  assign syncBusSync  = syncIn[0];

  // ***************************************
  // registers
  // ***************************************
  logic [7:0]          global_ff;
  logic [CHANNELS-1:0] status_ff;
  logic [CHANNELS-1:0] mask_ff;
  logic [CHANNELS-1:0] losPrev_ff;
  logic [7:0]          rdData_ff;

  logic irqEnable;
  logic regAutoOnes;
  assign irqEnable   = global_ff[alarm_cfg_pkg::GLB_IRQ_EN_BIT];
  assign regAutoOnes = global_ff[alarm_cfg_pkg::GLB_AUTO_ONES_BIT];

  logic wrGlobal;
  logic wrMask;
  logic rdStatus;
  assign wrGlobal = regWrite && (regAddr == alarm_cfg_pkg::OFS_GLOBAL);
  assign wrMask   = regWrite && (regAddr == alarm_cfg_pkg::OFS_MASK);
  assign rdStatus = regRead  && (regAddr == alarm_cfg_pkg::OFS_STATUS);

  // any change of loss-of-signal counts as an alarm event
  logic [CHANNELS-1:0] alarmChange;
  assign alarmChange = losSync ^ losPrev_ff; // RULE_04

  // set wins over the read-clear in the same cycle
  logic [CHANNELS-1:0] nxt_status;
  assign nxt_status = (rdStatus ? '0 : status_ff) | alarmChange; // RULE_05

  always_ff @(posedge clk) begin
    if (reset) begin
      global_ff  <= alarm_cfg_pkg::GLOBAL_RESET;
      mask_ff    <= alarm_cfg_pkg::MASK_RESET[CHANNELS-1:0];
      status_ff  <= '0;
      losPrev_ff <= '0;
    end else begin
      losPrev_ff <= losSync;
      status_ff  <= nxt_status;
      if (wrGlobal) begin
        global_ff <= regWrData;
      end
      if (wrMask) begin
        mask_ff <= regWrData[CHANNELS-1:0];
      end
    end
  end

  // read mux, data stands the cycle after the strobe
  logic [7:0] nxt_rdData;
  always_comb begin
    nxt_rdData = 8'h00;
    case (regAddr)
      alarm_cfg_pkg::OFS_GLOBAL: nxt_rdData = global_ff;
      alarm_cfg_pkg::OFS_STATUS: nxt_rdData = 8'(status_ff);
      alarm_cfg_pkg::OFS_MASK:   nxt_rdData = 8'(mask_ff);
      alarm_cfg_pkg::OFS_ALARM:  nxt_rdData = 8'(losSync);
      alarm_cfg_pkg::OFS_JITTER: nxt_rdData = {hwMode, refClockPresent, 4'h0, jaStrap};
      default:                   nxt_rdData = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rdData_ff <= 8'h00;
    end else begin
      rdData_ff <= regRead ? nxt_rdData : 8'h00;
    end
  end
  assign regRdData = rdData_ff;

  // ***************************************
  // interrupt output
  // ***************************************
  logic irqActive;
  assign irqActive = !hwMode && irqEnable && |(status_ff & mask_ff); // RULE_06

  logic irqOe_ff;
  always_ff @(posedge clk) begin
    if (reset) begin
      irqOe_ff <= 1'b0;
    end else begin
      irqOe_ff <= irqActive;
    end
  end
  assign alarmIrqOut = 1'b0; // RULE_07
  assign alarmIrqOe  = irqOe_ff; // RULE_07

  // ***************************************
  // automatic all ones on loss of signal
  // ***************************************
  logic autoOnesEn;
  assign autoOnesEn = hwMode ? strapAllOnes : regAutoOnes; // RULE_02 RULE_03

  logic [CHANNELS-1:0] txPos_ff;
  logic [CHANNELS-1:0] txNeg_ff;
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : g_ch
      logic forceOnes;
      // all ones on a bipolar line: marks alternate between rails
      logic alt_ff;
      assign forceOnes = autoOnesEn && losSync[ch]; // RULE_02 RULE_03
      always_ff @(posedge clk) begin
        if (reset) begin
          alt_ff       <= 1'b0;
          txPos_ff[ch] <= 1'b0;
          txNeg_ff[ch] <= 1'b0;
        end else if (forceOnes) begin
          if (refRise) begin
            alt_ff <= !alt_ff;
          end
          txPos_ff[ch] <= !alt_ff;
          txNeg_ff[ch] <= alt_ff;
        end else begin
          txPos_ff[ch] <= txPos[ch];
          txNeg_ff[ch] <= txNeg[ch];
        end
      end
    end
  endgenerate
  assign line_tx_pos = txPos_ff;
  assign line_tx_neg = txNeg_ff;

  // ***************************************
  // reference clock sampling
  // ***************************************
  logic        refPrev_ff;
  logic [7:0]  refIdle_ff;
  logic        synthClk_ff;
  logic        present_ff;
  assign refRise = refSync && !refPrev_ff; // RULE_09

  always_ff @(posedge clk) begin
    if (reset) begin
      refPrev_ff  <= 1'b0;
      refIdle_ff  <= 8'h00;
      synthClk_ff <= 1'b0;
      present_ff  <= 1'b0;
    end else begin
      refPrev_ff  <= refSync;
      synthClk_ff <= refSync; // RULE_08
      if (refRise) begin
        refIdle_ff <= 8'h00;
        present_ff <= 1'b1;
      end else if (refIdle_ff == 8'(alarm_cfg_pkg::REF_TIMEOUT_CYC)) begin
        present_ff <= 1'b0;
      end else begin
        refIdle_ff <= refIdle_ff + 8'h01;
      end
    end
  end
  assign synth_master_clock_out = synthClk_ff; // RULE_08
  assign refClockPresent        = present_ff;

  // ***************************************
  // jitter attenuator strap decode
  // ***************************************
  function automatic alarm_cfg_pkg::ja_cfg_s decodeJa(input logic [1:0] code);
    alarm_cfg_pkg::ja_cfg_s c;
    c = '{path: alarm_cfg_pkg::JA_PATH_NONE, narrowBand: 1'b0, fifoDepth: 7'h00};
    case (code)
      alarm_cfg_pkg::JA_OFF:     c.path = alarm_cfg_pkg::JA_PATH_NONE;
      alarm_cfg_pkg::JA_TX_10HZ: begin
        c.path      = alarm_cfg_pkg::JA_PATH_TX;
        c.fifoDepth = alarm_cfg_pkg::FIFO_DEPTH_32;
      end
      alarm_cfg_pkg::JA_RX_10HZ: begin
        c.path      = alarm_cfg_pkg::JA_PATH_RX;
        c.fifoDepth = alarm_cfg_pkg::FIFO_DEPTH_32;
      end
      alarm_cfg_pkg::JA_RX_1HZ5: begin
        c.path       = alarm_cfg_pkg::JA_PATH_RX;
        c.narrowBand = 1'b1;
        c.fifoDepth  = alarm_cfg_pkg::FIFO_DEPTH_64;
      end
      default:                   c.path = alarm_cfg_pkg::JA_PATH_NONE;
    endcase
    return c;
  endfunction

  alarm_cfg_pkg::ja_cfg_s jaCfg_ff;
  always_ff @(posedge clk) begin
    if (reset) begin
      jaCfg_ff <= '0;
    end else begin
      jaCfg_ff <= hwMode ? decodeJa(jaStrap) : decodeJa(alarm_cfg_pkg::JA_OFF); // RULE_10
    end
  end
  assign jitterCfg = jaCfg_ff;

  // ***************************************
  // host bus clock selection
  // ***************************************
  // bus logic in the wider device takes hostBusClock when this is high
  logic busSel_ff;
  always_ff @(posedge clk) begin
    if (reset) begin
      busSel_ff <= 1'b0;
    end else begin
      busSel_ff <= !hwMode && syncBusSync; // RULE_01
    end
  end
  assign busClockSel = busSel_ff;

  // ***************************************
  // assertions
  // ***************************************
  property p_irq_open_drain;
    @(posedge clk) disable iff (reset) alarmIrqOut == 1'b0;
  endproperty
  a_irq_open_drain: assert property (p_irq_open_drain) else $error("irq drives high"); // RULE_07

  property p_irq_gate;
    @(posedge clk) disable iff (reset) !irqEnable |=> !alarmIrqOe;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq while disabled"); // RULE_06

  property p_change_raises;
    @(posedge clk) disable iff (reset)
      (|(alarmChange & mask_ff) && irqEnable && !hwMode && $stable(global_ff)
       && $stable(hwMode)) |=> ##1 alarmIrqOe;
  endproperty
  a_change_raises: assert property (p_change_raises) else $error("no irq on change"); // RULE_04

  property p_read_clears;
    @(posedge clk) disable iff (reset) (rdStatus && alarmChange == '0) |=> status_ff == '0;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("status not cleared"); // RULE_05

  property p_hw_no_irq;
    @(posedge clk) disable iff (reset) hwMode |=> !alarmIrqOe;
  endproperty
  a_hw_no_irq: assert property (p_hw_no_irq) else $error("irq in hardware mode"); // RULE_11

  property p_all_ones;
    @(posedge clk) disable iff (reset)
      (hwMode && strapAllOnes) |=>
        ((line_tx_pos ^ line_tx_neg) & $past(losSync)) == $past(losSync);
  endproperty
  a_all_ones: assert property (p_all_ones) else $error("no all ones on loss"); // RULE_02

  property p_all_ones_host;
    @(posedge clk) disable iff (reset)
      (!hwMode && regAutoOnes) |=>
        ((line_tx_pos ^ line_tx_neg) & $past(losSync)) == $past(losSync);
  endproperty
  a_all_ones_host: assert property (p_all_ones_host) else $error("host all ones missing"); // RULE_03

  property p_clock_follow;
    @(posedge clk) disable iff (reset)
      (!$past(reset) && !$past(reset, 2) && !$past(reset, 3))
        |-> synth_master_clock_out == $past(e1_reference_clock_in, 3);
  endproperty
  a_clock_follow: assert property (p_clock_follow) else $error("clock out lags"); // RULE_08

  property p_ja_decode;
    @(posedge clk) disable iff (reset)
      (hwMode && jaStrap == 2'h3) |=> jitterCfg.fifoDepth == 7'h40;
  endproperty
  a_ja_decode: assert property (p_ja_decode) else $error("jitter decode wrong"); // RULE_10

  property p_bus_clock;
    @(posedge clk) disable iff (reset) hwMode |=> !busClockSel;
  endproperty
  a_bus_clock: assert property (p_bus_clock) else $error("bus clock in hw mode"); // RULE_01

endmodule // alarm_irq_strap

// ==== verif/host_model.sv ====
// host processor model: register master, interrupt pull-up, reference and bus clocks
`timescale 1ns/1ps
module host_model (
  input  wire logic       clk,
  input  wire logic       refRun,
  input  wire logic [7:0] regRdData,
  input  wire logic       alarmIrqOut,
  input  wire logic       alarmIrqOe,
  output logic      [3:0] regAddr,
  output logic      [7:0] regWrData,
  output logic            regWrite,
  output logic            regRead,
  output logic            e1_reference_clock_in,
  output logic            hostBusClock,
  output wire logic       irqLine
);
  // external pull-up resolves the released line high
  assign irqLine = alarmIrqOe ? alarmIrqOut : 1'b1;
  initial begin
    {regAddr, regWrData, regWrite, regRead} = 14'h0000;
    e1_reference_clock_in = 1'b0;
    hostBusClock = 1'b0;
  end
  always #62.5 hostBusClock = ~hostBusClock;
  // reference held low while stopped
  always #244.140625 e1_reference_clock_in = refRun & ~e1_reference_clock_in;
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
    regWrData <= ~d;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    @(posedge clk);
    d = regRdData;
  endtask
endmodule // host_model

// ==== verif/testbench.sv ====
// testbench: alarm interrupt, all-ones, strap decode and clock scenarios
`timescale 1ns/1ps
module testbench;
  logic clk, reset, config_mode_select, auto_all_ones_on_los, syncBusMode, refRun;
  logic jitter_path_select_lo, jitter_path_select_hi, e1_reference_clock_in, hostBusClock;
  logic [7:0] lossOfSignal, txPos, txNeg, regWrData, regRdData, line_tx_pos, line_tx_neg, d;
  logic [3:0] regAddr;
  logic regWrite, regRead, alarmIrqOut, alarmIrqOe, synth_master_clock_out;
  logic refClockPresent, busClockSel, irqLine;
  alarm_cfg_pkg::ja_cfg_s jitterCfg;
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;
  alarm_irq_strap i_dut (.clk, .reset, .config_mode_select, .auto_all_ones_on_los,
    .jitter_path_select_lo, .jitter_path_select_hi, .e1_reference_clock_in, .hostBusClock,
    .syncBusMode, .lossOfSignal, .txPos, .txNeg, .regAddr, .regWrData, .regWrite, .regRead,
    .regRdData, .line_tx_pos, .line_tx_neg, .alarmIrqOut, .alarmIrqOe,
    .synth_master_clock_out, .refClockPresent, .jitterCfg, .busClockSel);
  host_model i_host (.clk, .refRun, .regRdData, .alarmIrqOut, .alarmIrqOe, .regAddr,
    .regWrData, .regWrite, .regRead, .e1_reference_clock_in, .hostBusClock, .irqLine);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      bad_count++;
      conclude();
    end
  end
  task automatic chk(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask
  task automatic rdChk(input logic [3:0] a, input logic [7:0] e, input string msg);
    i_host.rd(a, d);
    chk(d === e, msg);
  endtask
  task automatic quiet(input string msg);
    repeat (12) begin
      @(posedge clk);
      chk(alarmIrqOe === 1'b0, msg);
    end
  endtask
  task automatic waitOe(input logic v, input string msg);
    int k;
    k = 0;
    while (alarmIrqOe !== v && k < 8) begin
      @(posedge clk);
      k++;
    end
    chk(alarmIrqOe === v, msg);
  endtask
  // ************
  // scenarios
  // ************
  task automatic t_reset();
    chk(alarmIrqOe === 1'b0, "irq after reset");
    rdChk(alarm_cfg_pkg::OFS_GLOBAL, alarm_cfg_pkg::GLOBAL_RESET, "global reset");
    rdChk(alarm_cfg_pkg::OFS_MASK, alarm_cfg_pkg::MASK_RESET, "mask reset");
    rdChk(4'hF, 8'h00, "unmapped read");
    i_host.wr(alarm_cfg_pkg::OFS_STATUS, 8'hFF);
    rdChk(alarm_cfg_pkg::OFS_STATUS, 8'h00, "status not writable");
  endtask
  task automatic t_jitter();
    for (int c = 0; c < 4; c++) begin
      @(posedge clk);
      {jitter_path_select_hi, jitter_path_select_lo} <= 2'(c);
      repeat (6) @(posedge clk);
      chk(jitterCfg.path === (c == 0 ? alarm_cfg_pkg::JA_PATH_NONE : c == 1 ?
        alarm_cfg_pkg::JA_PATH_TX : alarm_cfg_pkg::JA_PATH_RX), "ja path");
      chk(c == 0 || jitterCfg.narrowBand === (c == 3), "ja band");
      chk(c == 0 || jitterCfg.fifoDepth === (c == 3 ? alarm_cfg_pkg::FIFO_DEPTH_64 :
        alarm_cfg_pkg::FIFO_DEPTH_32), "ja depth");
      rdChk(alarm_cfg_pkg::OFS_JITTER, 8'hC0 | 8'(c), "ja read");
    end
    @(posedge clk);
    config_mode_select <= 1'b0;
    repeat (6) @(posedge clk);
    chk(jitterCfg.path === alarm_cfg_pkg::JA_PATH_NONE, "host mode ja");
    rdChk(alarm_cfg_pkg::OFS_JITTER, 8'h43, "host mode ja read");
  endtask
  task automatic t_ones(input logic hw, input logic strap, input logic [7:0] g, input logic e);
    int p, n, o;
    {p, n, o} = '0;
    @(posedge clk);
    config_mode_select <= hw;
    auto_all_ones_on_los <= strap;
    i_host.wr(alarm_cfg_pkg::OFS_GLOBAL, g);
    @(posedge clk);
    lossOfSignal <= 8'h08;
    repeat (1200) begin
      @(posedge clk);
      p += int'(line_tx_pos[3] === 1'b1);
      n += int'(line_tx_neg[3] === 1'b1);
      o += int'((line_tx_pos | line_tx_neg) & 8'hF7) != 0;
    end
    chk((p > 0) === e && (n > 0) === e && o == 0, "all ones on loss");
    lossOfSignal <= 8'h00;
    txPos <= 8'hA5;
    txNeg <= 8'h5A;
    repeat (8) @(posedge clk);
    chk(line_tx_pos === 8'hA5 && line_tx_neg === 8'h5A, "rails pass through");
    txPos <= 8'h00;
    txNeg <= 8'h00;
    i_host.rd(alarm_cfg_pkg::OFS_STATUS, d);
  endtask
  task automatic t_irq();
    i_host.wr(alarm_cfg_pkg::OFS_GLOBAL, 8'h01);
    lossOfSignal <= 8'h10;
    waitOe(1'b1, "irq on change");
    chk(irqLine === 1'b0 && alarmIrqOut === 1'b0, "line pulled low");
    rdChk(alarm_cfg_pkg::OFS_STATUS, 8'h10, "status bit");
    waitOe(1'b0, "irq released");
    chk(irqLine === 1'b1, "line released high");
    rdChk(alarm_cfg_pkg::OFS_STATUS, 8'h00, "status cleared");
    i_host.wr(alarm_cfg_pkg::OFS_GLOBAL, 8'h00);
    lossOfSignal <= 8'h00;
    quiet("irq while disabled");
    i_host.wr(alarm_cfg_pkg::OFS_MASK, 8'h00);
    i_host.wr(alarm_cfg_pkg::OFS_GLOBAL, 8'h01);
    lossOfSignal <= 8'h01;
    quiet("irq while masked");
    i_host.wr(alarm_cfg_pkg::OFS_MASK, 8'hFF);
    waitOe(1'b1, "irq after unmask");
    rdChk(alarm_cfg_pkg::OFS_STATUS, 8'h11, "both changes kept");
    config_mode_select <= 1'b1;
    repeat (6) @(posedge clk);
    lossOfSignal <= 8'h00;
    quiet("irq in hardware mode");
    i_host.rd(alarm_cfg_pkg::OFS_STATUS, d);
  endtask
  task automatic t_clock();
    int r;
    logic q;
    {r, q} = '0;
    syncBusMode <= 1'b1;
    repeat (6) @(posedge clk);
    chk(busClockSel === 1'b0, "hw mode bus clock");
    config_mode_select <= 1'b0;
    repeat (6) @(posedge clk);
    chk(busClockSel === 1'b1, "sync bus clock");
    repeat (2441) begin
      @(posedge clk);
      r += int'(synth_master_clock_out === 1'b1 && q === 1'b0);
      q = synth_master_clock_out;
    end
    chk(r >= 49 && r <= 51 && refClockPresent === 1'b1, "master clock rate");
    refRun <= 1'b0;
    repeat (300) @(posedge clk);
    chk(refClockPresent === 1'b0, "reference lost");
    refRun <= 1'b1;
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    {reset, config_mode_select, refRun} = 3'b111;
    {auto_all_ones_on_los, syncBusMode, jitter_path_select_lo, jitter_path_select_hi} = 4'h0;
    {lossOfSignal, txPos, txNeg} = 24'h000000;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    repeat (6) @(posedge clk);
    t_reset();
    t_jitter();
    t_ones(1'b1, 1'b1, 8'h00, 1'b1);
    t_ones(1'b1, 1'b0, 8'h00, 1'b0);
    t_ones(1'b0, 1'b1, 8'h00, 1'b0);
    t_ones(1'b0, 1'b0, 8'h02, 1'b1);
    t_irq();
    t_clock();
    conclude();
  end
endmodule // testbench
